// file: rtl/sba_slave.sv
// Two-wire slave for RAM/EEPROM block access with packet error check on block reads.
// Assumes SCL/SDA pins arrive asynchronously and a memory beside it
// answers mem_rdata combinationally from mem_addr on this clock.
`timescale 1ns/1ps
`default_nettype none

module sba_slave
  import sba_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = sba_pkg::DEV_ADDR_DEF,
  parameter int PROG_CYC = sba_pkg::EE_PROG_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Bus pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Memory read side
  output logic [15:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  // Memory write side
  output logic mem_wr_en,
  output logic mem_wr_ee,
  output logic [15:0] mem_wr_addr,
  output logic [7:0] mem_wr_data
);
  import sba_pkg::*;

  function automatic logic in_ee(input logic [7:0] hi);
    in_ee = (hi >= EE_HI_MIN) && (hi <= EE_HI_MAX);
  endfunction

  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    crc8 = r;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  logic [2:0] scl_p, sda_p;
  sba_state_type state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] sh_r, tx_r, cmd_r, crc_r, mem_wr_data_r;
  logic [5:0] idx_r, cnt_r;
  logic [15:0] ptr_r, mem_wr_addr_r, prog_cnt_r;
  logic rd_go_r, ack_drv_r, blk_rd_r, mem_wr_en_r, mem_wr_ee_r;

  // Pins pass two flops; the third stage only serves edge detection
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      scl_p <= 3'h7;
      sda_p <= 3'h7;
    end else begin
      scl_p <= {scl_p[1:0], scl_i};
      sda_p <= {sda_p[1:0], sda_i};
    end
  end

  wire scl_s = scl_p[1];
  wire sda_s = sda_p[1];
  wire scl_rise = scl_s & ~scl_p[2];
  wire scl_fall = ~scl_s & scl_p[2];
  wire start_ev = scl_s & scl_p[2] & sda_p[2] & ~sda_s;
  wire stop_ev = scl_s & scl_p[2] & ~sda_p[2] & sda_s;
  wire byte_done = scl_fall && (bit_cnt_r == BIT_LAST);
  wire ack_end = scl_fall && (bit_cnt_r == BIT_ACK);
  wire active = (state_r != ST_IDLE) && (state_r != ST_IGN);
  wire addr_hit = (sh_r[7:1] == DEV_ADDR);
  wire cmd_ok = (sh_r <= RAM_TOP) || in_ee(sh_r) ||
                (sh_r == CMD_BLK_WR) || (sh_r == CMD_BLK_RD);
  wire blk_data = (cmd_r == CMD_BLK_WR) && (idx_r != 6'h00) &&
                  (idx_r <= cnt_r);
  wire do_wr = (state_r == ST_DATA) && byte_done &&
               (((cmd_r <= RAM_TOP) && (idx_r == 6'h00)) ||
                (in_ee(cmd_r) && (idx_r == 6'h01)) || blk_data);
  wire idx_nxt_en = (idx_r != IDX_SAT);
  wire rd_data_idx = (idx_r != 6'h00) && (idx_r <= BLK_MAX);
  wire [7:0] rd_byte = !blk_rd_r ?
                       ((idx_r == 6'h00) ? mem_rdata : IDLE_BYTE) :
                       (idx_r == 6'h00) ? BLK_RD_CNT :
                       rd_data_idx ? mem_rdata :
                       (idx_r == PEC_IDX) ? crc_r : IDLE_BYTE;

  //////////////////////////////////////////////////////////////////////////
  // Bit engine; sh_r also captures our own driven bits on reads
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bit_cnt_r <= 4'h0;
      sh_r <= 8'h00;
      rd_go_r <= 1'b0;
    end else if (start_ev) begin
      bit_cnt_r <= 4'hF; // Wraps to zero on the SCL fall after START
    end else if (scl_rise) begin
      if (bit_cnt_r != BIT_ACK) sh_r <= {sh_r[6:0], sda_s};
      else rd_go_r <= ~sda_s;
    end else if (scl_fall) begin
      bit_cnt_r <= (bit_cnt_r == BIT_ACK) ? 4'h0 : bit_cnt_r + 4'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      ack_drv_r <= 1'b0;
      blk_rd_r <= 1'b0;
      cmd_r <= 8'h00;
      idx_r <= 6'h00;
      cnt_r <= 6'h00;
      ptr_r <= 16'h0000;
    end else if (stop_ev) begin
      state_r <= ST_IDLE;
      ack_drv_r <= 1'b0;
      blk_rd_r <= 1'b0;
    end else if (start_ev) begin
      state_r <= ST_ADDR;
      ack_drv_r <= 1'b0;
    end else if (byte_done) begin
      case (state_r)
        ST_ADDR: begin
          ack_drv_r <= addr_hit;
          idx_r <= 6'h00;
          state_r <= !addr_hit ? ST_IGN : sh_r[0] ? ST_READ : ST_CMD;
        end
        ST_CMD: begin
          ack_drv_r <= cmd_ok;
          cmd_r <= sh_r;
          state_r <= cmd_ok ? ST_DATA : ST_IGN;
          blk_rd_r <= (sh_r == CMD_BLK_RD);
          if (sh_r <= RAM_TOP) ptr_r <= {8'h00, sh_r};
        end
        ST_DATA: begin
          ack_drv_r <= 1'b1;
          if (idx_nxt_en) idx_r <= idx_r + 6'h01;
          if (in_ee(cmd_r) && (idx_r == 6'h00)) ptr_r <= {cmd_r, sh_r};
          if ((cmd_r == CMD_BLK_WR) && (idx_r == 6'h00)) begin
            cnt_r <= (sh_r > {2'b00, BLK_MAX}) ? BLK_MAX : sh_r[5:0];
          end
          if (do_wr && blk_data) ptr_r <= ptr_r + 16'h0001;
        end
        default: ;
      endcase
    end else if (ack_end) begin
      ack_drv_r <= 1'b0;
      if (state_r == ST_READ) begin
        if (!rd_go_r) begin
          state_r <= ST_IGN;
        end else begin
          if (idx_nxt_en) idx_r <= idx_r + 6'h01;
          if (blk_rd_r && rd_data_idx) ptr_r <= ptr_r + 16'h0001;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Transmit next byte after ack
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_r <= 8'hFF;
    end else if (ack_end && (state_r == ST_READ) && rd_go_r) begin
      tx_r <= rd_byte;
    end else if (scl_fall && (bit_cnt_r < BIT_LAST)) begin
      tx_r <= {tx_r[6:0], 1'b1};
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      crc_r <= 8'h00;
    end else if (stop_ev || (start_ev && !active)) begin
      crc_r <= 8'h00;
    end else if (byte_done && active) begin
      crc_r <= crc8(crc_r, sh_r);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prog_cnt_r <= 16'h0000;
      mem_wr_en_r <= 1'b0;
      mem_wr_ee_r <= 1'b0;
      mem_wr_addr_r <= 16'h0000;
      mem_wr_data_r <= 8'h00;
    end else begin
      mem_wr_en_r <= do_wr;
      if (do_wr) begin
        mem_wr_ee_r <= in_ee(ptr_r[15:8]);
        mem_wr_addr_r <= ptr_r;
        mem_wr_data_r <= sh_r;
      end
      if (do_wr && in_ee(ptr_r[15:8])) prog_cnt_r <= 16'(PROG_CYC);
      else if (prog_cnt_r != 16'h0000) prog_cnt_r <= prog_cnt_r - 16'h0001;
    end
  end

  // Pins are open drain: both lines only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = (prog_cnt_r != 16'h0000);
  assign sda_oe = ack_drv_r | ((state_r == ST_READ) &&
                  (bit_cnt_r != BIT_ACK) && !tx_r[7]);
  assign mem_addr = ptr_r;
  assign mem_wr_en = mem_wr_en_r;
  assign mem_wr_ee = mem_wr_ee_r;
  assign mem_wr_addr = mem_wr_addr_r;
  assign mem_wr_data = mem_wr_data_r;

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_ee_wr;
    mem_wr_en_r && mem_wr_ee_r;
  endsequence
  sequence s_rd_load;
    ack_end && (state_r == ST_READ) && rd_go_r;
  endsequence

  chk_cmd_ack: assert property (
    byte_done && (state_r == ST_CMD) && (sh_r == CMD_BLK_WR)
    |=> ack_drv_r && (state_r == ST_DATA))
    else $error("block write command not acknowledged");
  chk_data_ack: assert property (
    byte_done && (state_r == ST_DATA) |=> ack_drv_r)
    else $error("write data byte not acknowledged");
  chk_count_cap: assert property (
    byte_done && (state_r == ST_DATA) && (cmd_r == CMD_BLK_WR) &&
    (idx_r == 6'h00) |=> (cnt_r <= BLK_MAX))
    else $error("block count above limit");
  chk_ee_stretch: assert property (
    s_ee_wr |-> scl_oe [*8])
    else $error("SCL not held during EEPROM programming");
  chk_recv_byte: assert property (
    s_rd_load and !blk_rd_r && (idx_r == 6'h00)
    |=> tx_r == $past(mem_rdata))
    else $error("receive byte not from memory");
  chk_blk_count: assert property (
    s_rd_load and blk_rd_r && (idx_r == 6'h00) |=> tx_r == BLK_RD_CNT)
    else $error("block read count byte wrong");
  chk_pec_slot: assert property (
    s_rd_load and blk_rd_r && (idx_r == PEC_IDX) |=> tx_r == $past(crc_r))
    else $error("check byte not after last data");
  chk_ptr_step: assert property (
    do_wr && blk_data |=> ptr_r == $past(ptr_r) + 16'h0001)
    else $error("block write pointer did not advance");
  chk_ram_range: assert property (
    mem_wr_en_r && !mem_wr_ee_r |-> mem_wr_addr_r <= {8'h00, RAM_TOP})
    else $error("RAM write outside range");
  chk_ee_range: assert property (
    s_ee_wr |-> in_ee(mem_wr_addr_r[15:8]))
    else $error("EEPROM write outside range");
  chk_crc_seed: assert property (
    stop_ev |=> crc_r == 8'h00)
    else $error("check value not cleared at stop");
endmodule
`default_nettype wire

// file: rtl/sba_pkg.sv
// Constants and types for the two-wire block access slave.
// Assumes a 25 MHz system clock and a bus master that drives SCL.
package sba_pkg;
  localparam logic [7:0] CMD_BLK_WR = 8'hFC;
  localparam logic [7:0] CMD_BLK_RD = 8'hFD;
  localparam logic [7:0] RAM_TOP = 8'hDF;
  localparam logic [7:0] EE_HI_MIN = 8'hF8;
  localparam logic [7:0] EE_HI_MAX = 8'hFB;
  localparam logic [7:0] BLK_RD_CNT = 8'h20;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  localparam logic [5:0] BLK_MAX = 6'h20;
  localparam logic [5:0] PEC_IDX = 6'h21;
  localparam logic [5:0] IDX_SAT = 6'h3F;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  // Arbitrary default slave address
  localparam logic [6:0] DEV_ADDR_DEF = 7'h34;
  localparam int EE_PROG_US = 250;
  localparam int CLK_MHZ = 25;
  localparam int EE_PROG_CYC = EE_PROG_US * CLK_MHZ;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_CMD = 3'h3,
    ST_DATA = 3'h2,
    ST_READ = 3'h6,
    ST_IGN = 3'h4
  } sba_state_type;
endpackage

// file: dv/sba_master.sv
// Two-wire bus master model that drives the slave's pins.
// Assumes the bench resolves both lines with pull-ups.
`timescale 1ns/1ps
`default_nettype none
module sba_master (
  // Clock
  input wire logic ref_clk,
  // Resolved bus lines
  input wire logic scl,
  input wire logic sda,
  // Master pull-downs, low pulls the line
  output var logic scl_m,
  output var logic sda_m
);
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // a stretched clock is waited out
  task automatic rise();
    scl_m <= 1'b1;
    do @(posedge ref_clk); while (scl !== 1'b1);
  endtask
  // Start, or repeated start when SCL is low; the long low phase makes
  // sure a slave ack is gone before SCL rises, else SDA rising reads as STOP
  task automatic start();
    sda_m <= 1'b1;
    tick(4);
    rise();
    tick(3);
    sda_m <= 1'b0;
    tick(4);
    scl_m <= 1'b0;
  endtask
  task automatic stop();
    tick(2);
    sda_m <= 1'b0;
    tick(2);
    rise();
    tick(3);
    sda_m <= 1'b1;
    tick(4);
  endtask
  // Data changes only in the low phase, sampled mid high phase
  task automatic bit_x(input logic b, output logic s);
    tick(2);
    sda_m <= b;
    tick(2);
    rise();
    tick(1);
    s = sda;
    tick(2);
    scl_m <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(d[i], s);
    bit_x(1'b1, s);
    ack = !s;
  endtask
  // acks each byte unless told to end the read
  task automatic rd(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, s);
      d[i] = s;
    end
    bit_x(!ack, s);
  endtask
endmodule
`default_nettype wire

// file: dv/sba_slave_tb.sv
// Self-checking bench for the block access slave.
// Assumes pull-ups on both lines and a flat 64K byte memory model.
`timescale 1ns/1ps
`default_nettype none
module sba_slave_tb;
  import sba_pkg::*;
  localparam int PROG = 20;
  logic ref_clk, resetn, scl, sda, scl_m, sda_m, scl_oe, sda_oe;
  logic mem_wr_en, mem_wr_ee, scl_o, sda_o;
  logic ee_seen = 1'b0;
  logic [15:0] mem_addr, mem_wr_addr;
  logic [7:0] mem_wr_data, pec;
  logic [7:0] mem [0:65535];
  int n_errors = 0, comparisons = 0, cycles = 0, run = 0, last_run = 0;
  assign scl = scl_m & ~scl_oe;
  assign sda = sda_m & ~sda_oe;
  sba_slave #(.PROG_CYC(PROG)) i_sba_slave (.ref_clk(ref_clk),
    .resetn(resetn), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .mem_addr(mem_addr),
    .mem_rdata(mem[mem_addr]), .mem_wr_en(mem_wr_en),
    .mem_wr_ee(mem_wr_ee), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data));
  sba_master i_sba_master (.ref_clk(ref_clk), .scl(scl), .sda(sda),
    .scl_m(scl_m), .sda_m(sda_m));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  // Memory model, stretch length and watchdog
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (mem_wr_en === 1'b1) begin
      mem[mem_wr_addr] <= mem_wr_data;
      ee_seen <= mem_wr_ee;
    end
    run <= (scl_oe === 1'b1) ? run + 1 : 0;
    if (scl_oe !== 1'b1 && run != 0) last_run <= run;
    if (cycles == 30000) begin
      n_errors++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [7:0] crc8(input logic [7:0] c, d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) r = {r[6:0], 1'b0} ^ (r[7] ? CRC_POLY : 8'h00);
    return r;
  endfunction
  task automatic wb(input logic [7:0] d, input logic ok);
    logic a;
    i_sba_master.wr(d, a);
    pec = crc8(pec, d);
    check("ack", {15'h0, a}, {15'h0, ok});
  endtask
  task automatic rb(input logic [7:0] exp, input logic ack, input string nm);
    logic [7:0] d;
    i_sba_master.rd(ack, d);
    check(nm, {8'h0, d}, {8'h0, exp});
    pec = crc8(pec, exp);
  endtask
  task automatic set_ptr(input logic [7:0] hi, lo, input logic ee);
    i_sba_master.start();
    wb({DEV_ADDR_DEF, 1'b0}, 1'b1);
    if (ee) wb(hi, 1'b1);
    wb(lo, 1'b1);
    i_sba_master.stop();
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_blk_wr(input logic [7:0] hi, lo, input logic ee);
    set_ptr(hi, lo, ee);
    pec = 8'h00;
    i_sba_master.start();
    wb({DEV_ADDR_DEF, 1'b0}, 1'b1);
    wb(CMD_BLK_WR, 1'b1);
    wb(8'h03, 1'b1);
    for (int i = 0; i < 3; i++) wb(8'hA0 + i[7:0], 1'b1);
    wb(pec, 1'b1);
    i_sba_master.stop();
    for (int i = 0; i < 3; i++) check("wr", {8'h0, mem[{hi, lo} + i]}, 16'h00A0 + i[15:0]);
    check("ee", {15'h0, ee_seen}, {15'h0, ee});
    if (ee) check("stretch", last_run[15:0], PROG[15:0]);
  endtask
  task automatic t_rx();
    set_ptr(8'h00, 8'h11, 1'b0);
    i_sba_master.start();
    wb({DEV_ADDR_DEF, 1'b1}, 1'b1);
    rb(8'hA1, 1'b0, "rx");
    i_sba_master.stop();
  endtask
  task automatic t_blk_rd();
    set_ptr(8'h00, 8'h0E, 1'b0);
    pec = 8'h00;
    i_sba_master.start();
    wb({DEV_ADDR_DEF, 1'b0}, 1'b1);
    wb(CMD_BLK_RD, 1'b1);
    i_sba_master.start();
    wb({DEV_ADDR_DEF, 1'b1}, 1'b1);
    rb(8'h20, 1'b1, "count");
    for (int i = 0; i < 32; i++) rb(mem[16'h000E + i], 1'b1, "data");
    rb(pec, 1'b0, "pec");
    i_sba_master.stop();
  endtask
  task automatic t_bad();
    i_sba_master.start();
    wb({DEV_ADDR_DEF, 1'b0}, 1'b1);
    wb(8'hE0, 1'b0);
    i_sba_master.stop();
    i_sba_master.start();
    wb({DEV_ADDR_DEF ^ 7'h01, 1'b0}, 1'b0);
    i_sba_master.stop();
    check("pins", {14'h0, scl_o, sda_o}, 16'h0000);
  endtask
  task automatic results();
    if (n_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    resetn = 1'b0;
    for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ 8'h5A;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_blk_wr(8'h00, 8'h10, 1'b0);
    t_rx();
    t_blk_wr(8'hF8, 8'hFE, 1'b1);
    t_blk_rd();
    t_bad();
    results();
  end
endmodule
`default_nettype wire
